// ===== accessory_regs_defs.vh
// Register offsets, field positions, reset values and timing for the accessory register bank.
// Assumes the including file supplies the ULPI clock at the rate given below.
`ifndef ACCESSORY_REGS_DEFS_VH
`define ACCESSORY_REGS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (6-bit ULPI immediate address)
// ----------------------------------------------------------------------
`define ADDR_LINE_STATE_DEBUG  6'h15
`define ADDR_SCRATCH_WR        6'h16
`define ADDR_SCRATCH_SET       6'h17
`define ADDR_SCRATCH_CLR       6'h18
`define ADDR_ACC_CTRL_WR       6'h19
`define ADDR_ACC_CTRL_SET      6'h1A
`define ADDR_ACC_CTRL_CLR      6'h1B
`define ADDR_ACC_IRQ_EN_WR     6'h1D
`define ADDR_ACC_IRQ_EN_SET    6'h1E
`define ADDR_ACC_IRQ_EN_CLR    6'h1F
`define ADDR_ACC_IRQ_STATUS    6'h20
`define ADDR_RES_CONV_WR       6'h36
`define ADDR_RES_CONV_SET      6'h37
`define ADDR_RES_CONV_CLR      6'h38

// ----------------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------------
`define MASK_SCRATCH           8'hFF
`define MASK_ACC_CTRL          8'h0E
`define MASK_ACC_IRQ_EN        8'h23
`define MASK_RES_CONV          8'h70
`define RST_SCRATCH            8'h00
`define RST_ACC_CTRL           8'h00
`define RST_ACC_IRQ_EN         8'h00
`define RST_RES_CONV           8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_ID_GROUND_DRIVE    1
`define BIT_UART_TX_CONNECT    2
`define BIT_UART_RX_CONNECT    3
`define BIT_ID_FLOAT_RISE_EN   0
`define BIT_ID_FLOAT_FALL_EN   1
`define BIT_RES_DONE_EN        5
`define BIT_CONV_DONE          3
`define BIT_CONV_GO            4
`define BIT_CONV_DONE_EN       6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_PERIOD_NS      20
`define CONV_TIME_NS           282000
`define CONV_CYCLES            ((`CONV_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// ===== accessory_regs.v
// Accessory (carkit) control, scratch and line-state debug registers of a ULPI transceiver.
// Assumes the ULPI register engine on ref_clk decodes register commands into
// single-cycle read/write strobes with an immediate address, and builds RXCMD from alt_int.
`timescale 1ns/1ps
`include "accessory_regs_defs.vh"
`default_nettype none

module accessory_regs #(
  parameter integer CONV_CYCLES = `CONV_CYCLES
) (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rd_valid,
  input  wire [1:0] line_state,
  input  wire       id_float_raw,
  input  wire       dp_rx_in,
  input  wire       ulpi_data0_in,
  input  wire [2:0] id_code_in,
  input  wire       id_pullup_enable,
  input  wire       accessory_uart_mode,
  output reg        dm_uart_out,
  output reg        dm_uart_oe,
  output reg        ulpi_data1_out,
  output reg        ulpi_data1_oe,
  output reg        id_ground_drive,
  output reg        resistor_measure_go,
  output reg        alt_int
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Analog and pin inputs are asynchronous; the first stage feeds only the second.
  reg  [7:0] meta_ff;
  reg  [7:0] sync_ff;
  wire [7:0] async_in;

  assign async_in = {id_code_in, ulpi_data0_in, dp_rx_in, id_float_raw, line_state};

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  wire [1:0] line_state_s = sync_ff[1:0];
  wire       id_float_s   = sync_ff[2];
  wire       dp_s         = sync_ff[3];
  wire       data0_s      = sync_ff[4];
  wire [2:0] id_code_s    = sync_ff[7:5];

  // ----------------------------------------------------------------------
  // Write / set / clear merge
  // ----------------------------------------------------------------------
  // sel: 0 write, 1 set, 2 clear; bits outside mask never change
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    input [1:0] sel;
    reg   [7:0] val;
    begin
      case (sel)
        2'd0:    val = data;
        2'd1:    val = old | data;
        2'd2:    val = old & ~data;
        default: val = old;
      endcase
      merge = (val & mask) | (old & ~mask);
    end
  endfunction

  function [1:0] acc_sel;
    input [5:0] addr;
    input [5:0] base;
    begin
      acc_sel = (addr == base) ? 2'd0 :
                (addr == base + 6'h01) ? 2'd1 :
                (addr == base + 6'h02) ? 2'd2 : 2'd3;
    end
  endfunction

  wire [1:0] sel_scratch = acc_sel(reg_addr, `ADDR_SCRATCH_WR);
  wire [1:0] sel_ctrl    = acc_sel(reg_addr, `ADDR_ACC_CTRL_WR);
  wire [1:0] sel_irq_en  = acc_sel(reg_addr, `ADDR_ACC_IRQ_EN_WR);
  wire [1:0] sel_conv    = acc_sel(reg_addr, `ADDR_RES_CONV_WR);

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  reg  [7:0] scratch_ff;
  reg  [7:0] acc_ctrl_ff;
  reg  [7:0] acc_irq_en_ff;
  reg  [7:0] conv_ctrl_ff;
  wire       conv_finish;

  reg  [7:0] nxt_conv_ctrl;

  always @* begin
    nxt_conv_ctrl = conv_ctrl_ff;
    if (reg_wr_en && sel_conv != 2'd3)
      nxt_conv_ctrl = merge(conv_ctrl_ff, reg_wdata, `MASK_RES_CONV, sel_conv);
    if (conv_finish)
      nxt_conv_ctrl[`BIT_CONV_GO] = 1'b0;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scratch_ff    <= `RST_SCRATCH;
      acc_ctrl_ff   <= `RST_ACC_CTRL;
      acc_irq_en_ff <= `RST_ACC_IRQ_EN;
      conv_ctrl_ff  <= `RST_RES_CONV;
    end else begin
      if (reg_wr_en && sel_scratch != 2'd3)
        scratch_ff <= merge(scratch_ff, reg_wdata, `MASK_SCRATCH, sel_scratch);
      if (reg_wr_en && sel_ctrl != 2'd3)
        acc_ctrl_ff <= merge(acc_ctrl_ff, reg_wdata, `MASK_ACC_CTRL, sel_ctrl);
      if (reg_wr_en && sel_irq_en != 2'd3)
        acc_irq_en_ff <= merge(acc_irq_en_ff, reg_wdata, `MASK_ACC_IRQ_EN,
                               sel_irq_en);
      conv_ctrl_ff <= nxt_conv_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // Resistor conversion timer
  // ----------------------------------------------------------------------
  // The analog converter settles on its own; this timer marks when its code is valid.
  localparam CONV_IDLE = 1'b0;
  localparam CONV_RUN  = 1'b1;

  reg        conv_state_ff;
  reg [15:0] conv_cnt_ff;
  reg [2:0]  id_code_ff;
  reg        conv_done_ff;
  reg        nxt_conv_state;
  reg [15:0] nxt_conv_cnt;

  wire conv_start = nxt_conv_ctrl[`BIT_CONV_GO] & ~conv_ctrl_ff[`BIT_CONV_GO];
  assign conv_finish = (conv_state_ff == CONV_RUN) &&
                       (conv_cnt_ff == CONV_CYCLES[15:0] - 16'h0001);

  always @* begin
    nxt_conv_state = conv_state_ff;
    nxt_conv_cnt   = conv_cnt_ff;
    case (conv_state_ff)
      CONV_IDLE: begin
        nxt_conv_cnt = 16'h0000;
        if (conv_start)
          nxt_conv_state = CONV_RUN;
      end
      CONV_RUN: begin
        nxt_conv_cnt = conv_cnt_ff + 16'h0001;
        if (conv_finish)
          nxt_conv_state = CONV_IDLE;
        else if (!conv_ctrl_ff[`BIT_CONV_GO])
          nxt_conv_state = CONV_IDLE;
      end
      default: begin
        nxt_conv_state = CONV_IDLE;
        nxt_conv_cnt   = 16'h0000;
      end
    endcase
  end

  // Done set beats a clearing read in the same cycle
  wire rd_conv  = reg_rd_en && sel_conv != 2'd3;
  wire done_irq = conv_finish & (acc_irq_en_ff[`BIT_RES_DONE_EN] |
                                 conv_ctrl_ff[`BIT_CONV_DONE_EN]);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_state_ff <= CONV_IDLE;
      conv_cnt_ff   <= 16'h0000;
      id_code_ff    <= 3'h0;
      conv_done_ff  <= 1'b0;
    end else begin
      conv_state_ff <= nxt_conv_state;
      conv_cnt_ff   <= nxt_conv_cnt;
      if (conv_finish) begin
        id_code_ff   <= id_code_s;
        conv_done_ff <= 1'b1;
      end else if (rd_conv) begin
        conv_done_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // ID float detection and interrupt event
  // ----------------------------------------------------------------------
  // Without the pull-up the float comparator is meaningless, so it is gated off.
  wire id_float_q = id_float_s & id_pullup_enable;
  reg  id_float_ff;

  wire float_rise = id_float_q & ~id_float_ff;
  wire float_fall = ~id_float_q & id_float_ff;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      id_float_ff <= 1'b0;
      alt_int     <= 1'b0;
    end else begin
      id_float_ff <= id_float_q;
      alt_int     <= (float_rise & acc_irq_en_ff[`BIT_ID_FLOAT_RISE_EN]) |
                     (float_fall & acc_irq_en_ff[`BIT_ID_FLOAT_FALL_EN]) |
                     done_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `ADDR_LINE_STATE_DEBUG:
        rd_mux = {6'h00, line_state_s};
      `ADDR_SCRATCH_WR, `ADDR_SCRATCH_SET, `ADDR_SCRATCH_CLR:
        rd_mux = scratch_ff;
      `ADDR_ACC_CTRL_WR, `ADDR_ACC_CTRL_SET, `ADDR_ACC_CTRL_CLR:
        rd_mux = acc_ctrl_ff & `MASK_ACC_CTRL;
      `ADDR_ACC_IRQ_EN_WR, `ADDR_ACC_IRQ_EN_SET, `ADDR_ACC_IRQ_EN_CLR:
        rd_mux = acc_irq_en_ff & `MASK_ACC_IRQ_EN;
      `ADDR_ACC_IRQ_STATUS:
        rd_mux = {1'b0, conv_done_ff, id_code_ff, 2'b00, id_float_ff};
      `ADDR_RES_CONV_WR, `ADDR_RES_CONV_SET, `ADDR_RES_CONV_CLR:
        rd_mux = {1'b0, conv_ctrl_ff[6:4], conv_done_ff, id_code_ff};
      default:
        rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Accessory pin routing
  // ----------------------------------------------------------------------
  // The link sets the connect bits before entering UART mode, so the pads
  // never see a half-configured route.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      id_ground_drive     <= 1'b0;
      dm_uart_out         <= 1'b1;
      dm_uart_oe          <= 1'b0;
      ulpi_data1_out      <= 1'b1;
      ulpi_data1_oe       <= 1'b0;
      resistor_measure_go <= 1'b0;
    end else begin
      id_ground_drive     <= acc_ctrl_ff[`BIT_ID_GROUND_DRIVE];
      dm_uart_out         <= data0_s;
      dm_uart_oe          <= acc_ctrl_ff[`BIT_UART_TX_CONNECT];
      ulpi_data1_out      <= acc_ctrl_ff[`BIT_UART_RX_CONNECT] ? dp_s
                                                               : 1'b1;
      ulpi_data1_oe       <= accessory_uart_mode;
      resistor_measure_go <= (conv_state_ff == CONV_RUN);
    end
  end

endmodule

`default_nettype wire

// ===== accessory_regs_asserts.sv
// Checker for accessory_regs: register reads, pin routing and interrupt pulse timing.
// Assumes it is bound to accessory_regs; the control byte is shadowed from port writes.
`timescale 1ns/1ps
`include "accessory_regs_defs.vh"
`default_nettype none
module accessory_regs_asserts #(
  parameter integer CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rd_valid,
  input wire logic       dm_uart_oe,
  input wire logic       ulpi_data1_out,
  input wire logic       id_ground_drive,
  input wire logic       resistor_measure_go,
  input wire logic       alt_int
);
  logic [7:0] ctrl_ff;
  // Wide enough for the full-length conversion count
  logic [15:0] go_cnt_ff;
  logic [7:0] wmask;
  assign wmask = reg_wdata & `MASK_ACC_CTRL;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff   <= 8'h00;
      go_cnt_ff <= 16'h0000;
    end else begin
      go_cnt_ff <= resistor_measure_go ? go_cnt_ff + 16'h0001 : 16'h0000;
      if (reg_wr_en && reg_addr == `ADDR_ACC_CTRL_WR) ctrl_ff <= wmask;
      if (reg_wr_en && reg_addr == `ADDR_ACC_CTRL_SET) ctrl_ff <= ctrl_ff | wmask;
      if (reg_wr_en && reg_addr == `ADDR_ACC_CTRL_CLR) ctrl_ff <= ctrl_ff & ~reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rd_valid_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("read gave no valid");
  no_valid_a: assert property (!reg_rd_en |=> !reg_rd_valid) else $error("stray read valid");
  ctrl_read_a: assert property (reg_rd_en && reg_addr inside {[6'h19:6'h1B]}
    |=> reg_rdata == $past(ctrl_ff)) else $error("control readback wrong");
  id_gnd_a: assert property (id_ground_drive == $past(ctrl_ff[1])) else $error("id drive wrong");
  tx_oe_a: assert property (dm_uart_oe == $past(ctrl_ff[2])) else $error("dm enable wrong");
  rx_high_a: assert property (!$past(ctrl_ff[3]) |-> ulpi_data1_out) else $error("data1 low");
  debug_zero_a: assert property (reg_rd_en && reg_addr == `ADDR_LINE_STATE_DEBUG
    |=> reg_rdata[7:2] == 6'h00) else $error("debug upper bits set");
  status_zero_a: assert property (reg_rd_en && reg_addr == `ADDR_ACC_IRQ_STATUS
    |=> reg_rdata[7] == 1'b0 && reg_rdata[2:1] == 2'h0) else $error("status spare bits set");
  irq_en_zero_a: assert property (reg_rd_en && reg_addr inside {[6'h1D:6'h1F]}
    |=> (reg_rdata & 8'hDC) == 8'h00) else $error("enable spare bits set");
  alt_pulse_a: assert property (alt_int |=> !alt_int) else $error("alt_int not a pulse");
  go_len_a: assert property (go_cnt_ff <= CONV_CYCLES + 1) else $error("measure too long");
  cover property ($fell(resistor_measure_go));
  cover property (alt_int);
  cover property (reg_rd_en && reg_addr == `ADDR_ACC_IRQ_STATUS);
endmodule
bind accessory_regs accessory_regs_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .dm_uart_oe(dm_uart_oe), .ulpi_data1_out(ulpi_data1_out),
  .id_ground_drive(id_ground_drive), .resistor_measure_go(resistor_measure_go),
  .alt_int(alt_int));
`default_nettype wire

// ===== ulpi_link_model.sv
// ULPI link controller model: strobed register accesses and UART mode entry.
// Assumes the register port takes a strobe on a ref_clk rising edge.
`timescale 1ns/1ps
`include "accessory_regs_defs.vh"
`default_nettype none
module ulpi_link_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  output var  logic       reg_wr_en,
  output var  logic       reg_rd_en,
  output var  logic [5:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       accessory_uart_mode
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    accessory_uart_mode = 1'b0;
  end
  // Released lines flip so the block cannot lean on a stale value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    // Valid stands for one cycle only, so the answer is taken before release
    d = reg_rdata;
    v = reg_rd_valid;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask
  // Connects first, mode after, so the pins never switch half set up
  task automatic enter_uart();
    wr(`ADDR_ACC_CTRL_SET, 8'h0C);
    @(negedge ref_clk);
    accessory_uart_mode = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== accessory_regs_tb_top.sv
// Self-checking bench for accessory_regs: a table of register cases, then pins,
// interrupts, conversion and a mid-run reset. Assumes the link model owns the register port.
`timescale 1ns/1ps
`include "accessory_regs_defs.vh"
`default_nettype none
module accessory_regs_tb_top;
  localparam int CONV = 20;
  typedef struct packed {
    logic [5:0] wa;
    logic [7:0] wd;
    logic [5:0] ra;
    logic [7:0] ex;
  } row_t;
  logic       ref_clk, nrst, reg_wr_en, reg_rd_en, reg_rd_valid, id_float_raw, dp_rx_in;
  logic       ulpi_data0_in, id_pullup_enable, accessory_uart_mode, dm_uart_out, dm_uart_oe;
  logic       ulpi_data1_out, ulpi_data1_oe, id_ground_drive, resistor_measure_go, alt_int;
  logic       v, hit;
  logic [1:0] line_state;
  logic [2:0] id_code_in;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  int         failures, n_tests, g;
  row_t       rows [11] = '{
    '{`ADDR_SCRATCH_WR, 8'hA5, `ADDR_SCRATCH_WR, 8'hA5},
    '{`ADDR_SCRATCH_SET, 8'h0A, `ADDR_SCRATCH_SET, 8'hAF},
    '{`ADDR_SCRATCH_CLR, 8'h05, `ADDR_SCRATCH_CLR, 8'hAA},
    '{`ADDR_ACC_CTRL_WR, 8'hFF, `ADDR_ACC_CTRL_SET, 8'h0E},
    '{`ADDR_ACC_CTRL_CLR, 8'h04, `ADDR_ACC_CTRL_CLR, 8'h0A},
    '{`ADDR_ACC_IRQ_EN_WR, 8'hFF, `ADDR_ACC_IRQ_EN_SET, 8'h23},
    '{`ADDR_ACC_IRQ_EN_CLR, 8'h02, `ADDR_ACC_IRQ_EN_CLR, 8'h21},
    '{`ADDR_ACC_IRQ_EN_SET, 8'h02, `ADDR_ACC_IRQ_EN_WR, 8'h23},
    '{`ADDR_LINE_STATE_DEBUG, 8'hFF, `ADDR_LINE_STATE_DEBUG, 8'h02},
    '{`ADDR_ACC_IRQ_STATUS, 8'hFF, `ADDR_ACC_IRQ_STATUS, 8'h00},
    '{6'h3F, 8'hFF, 6'h3F, 8'h00}};
  accessory_regs #(.CONV_CYCLES(CONV)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .line_state(line_state), .id_float_raw(id_float_raw),
    .dp_rx_in(dp_rx_in), .ulpi_data0_in(ulpi_data0_in), .id_code_in(id_code_in),
    .id_pullup_enable(id_pullup_enable), .accessory_uart_mode(accessory_uart_mode),
    .dm_uart_out(dm_uart_out), .dm_uart_oe(dm_uart_oe), .ulpi_data1_out(ulpi_data1_out),
    .ulpi_data1_oe(ulpi_data1_oe), .id_ground_drive(id_ground_drive),
    .resistor_measure_go(resistor_measure_go), .alt_int(alt_int));
  ulpi_link_model i_link (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .accessory_uart_mode(accessory_uart_mode));
  task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk1(input string nm, input logic ex, input logic got);
    n_tests++;
    if (got !== ex) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, ex, got);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] ex);
    i_link.rd(a, d, v);
    chk1("rd_valid", 1'b1, v);
    chk8("rdata", ex, d);
  endtask
  // Counts measure cycles and catches a one-cycle alt_int pulse
  task automatic watch(input int n);
    g = 0;
    hit = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      if (resistor_measure_go === 1'b1) g++;
      if (alt_int === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic conclude();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    line_state = 2'b10;
    id_float_raw = 1'b0;
    dp_rx_in = 1'b1;
    ulpi_data0_in = 1'b1;
    id_code_in = 3'b101;
    id_pullup_enable = 1'b0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    // ------------------------------------------------------------
    // Table cases, then pins, interrupts, conversion, reset
    // ------------------------------------------------------------
    foreach (rows[i]) begin
      i_link.wr(rows[i].wa, rows[i].wd);
      rdchk(rows[i].ra, rows[i].ex);
    end
    dp_rx_in = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk1("data1_out", 1'b0, ulpi_data1_out);
    chk1("id_gnd", 1'b1, id_ground_drive);
    i_link.enter_uart();
    ulpi_data0_in = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk1("dm_out", 1'b0, dm_uart_out);
    chk1("dm_oe", 1'b1, dm_uart_oe);
    chk1("data1_oe", 1'b1, ulpi_data1_oe);
    i_link.wr(`ADDR_ACC_CTRL_CLR, 8'h08);
    repeat (3) @(negedge ref_clk);
    chk1("data1_idle", 1'b1, ulpi_data1_out);
    id_pullup_enable = 1'b1;
    id_float_raw = 1'b1;
    watch(10);
    chk1("rise_irq", 1'b1, hit);
    rdchk(`ADDR_ACC_IRQ_STATUS, 8'h01);
    id_float_raw = 1'b0;
    watch(10);
    chk1("fall_irq", 1'b1, hit);
    id_pullup_enable = 1'b0;
    id_float_raw = 1'b1;
    watch(10);
    chk1("gated_irq", 1'b0, hit);
    rdchk(`ADDR_ACC_IRQ_STATUS, 8'h00);
    i_link.wr(`ADDR_RES_CONV_SET, 8'h10);
    watch(40);
    chk1("done_irq", 1'b1, hit);
    chk1("go_len", 1'b1, g >= CONV && g <= CONV + 1);
    rdchk(`ADDR_ACC_IRQ_STATUS, 8'h68);
    rdchk(`ADDR_ACC_IRQ_STATUS, 8'h68);
    rdchk(`ADDR_RES_CONV_WR, 8'h0D);
    rdchk(`ADDR_ACC_IRQ_STATUS, 8'h28);
    i_link.wr(`ADDR_ACC_IRQ_EN_CLR, 8'h20);
    i_link.wr(`ADDR_RES_CONV_WR, 8'h50);
    watch(40);
    chk1("vendor_irq", 1'b1, hit);
    nrst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk1("id_gnd_rst", 1'b0, id_ground_drive);
    nrst = 1'b1;
    rdchk(`ADDR_SCRATCH_WR, 8'h00);
    rdchk(`ADDR_ACC_IRQ_EN_WR, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
